// *** hw/rtcs_defs.vh ***
// Constants for the two-wire slave port of the real-time clock.
// Assumes inclusion by bare name from the port module.
`ifndef RTCS_DEFS_VH
`define RTCS_DEFS_VH
`define RTCS_DEV_ADDR 7'h68
`define RTCS_LOC_COUNT 5'h14
`define RTCS_LOC_LAST 5'h13
`define RTCS_CLOCK_LAST 5'h07
`define RTCS_PTR_RESET 5'h00
`define RTCS_SYNC_INIT 3'h3
`define RTCS_ADDR_MSB 7
`define RTCS_RW_BIT 0
`define RTCS_BITS_PER_BYTE 4'h8
`define RTCS_FIFO_WIDTH 13
`define RTCS_FIFO_DEPTH 4
`define RTCS_FIFO_AW 2
`define RTCS_SCL_MIN_HIGH_NS 600
`define RTCS_CLK_NS 100
`define RTCS_SCL_HIGH_CYC ((`RTCS_SCL_MIN_HIGH_NS + `RTCS_CLK_NS - 1) / `RTCS_CLK_NS)
`endif

// *** hw/rtcs_fifo.v ***
// Holds no logic: the write FIFO module sits in the port's design file.
// Assumes nothing; reading it defines no module.

// *** hw/rtcs_port.v ***
// Two-wire slave port of a real-time clock: conditions, address match, pointer, byte moves.
// Assumes scl, sda and supply_low come from outside the clock domain; register storage sits outside.
// Behaviour
// R1 - Access opens with START and address byte; answer only to address D0h.
// R2 - Twenty byte locations reached in fixed sequence, clock bytes first.
// R3 - Supply below threshold aborts any transfer and clears the pointer.
// R4 - While supply is low, bus inputs are ignored entirely.
// R5 - Master starts only on an idle bus, both lines high.
// R6 - Data stable while clock high; changes then are control conditions.
// R7 - Data falling while clock high is START.
// R8 - Data rising while clock high is STOP.
// R9 - Eight-bit bytes, one clock per bit, acknowledge on ninth clock.
// R10 - Unlimited bytes between START and STOP. Code ignores the bus until next START once a data byte ends while the write FIFO is full.
// R11 - Acknowledger holds data low through the acknowledge clock high.
// R12 - Master skips last acknowledge; device then releases data line.
// R13 - Addressed read: write pointer, repeated START, read from pointer.
// R14 - Pointer advances by one only on an acknowledge clock.
// R15 - Each acknowledged read byte is followed by the next address.
// R16 - Clock copy frozen while pointer in 00h-07h; resumes on STOP or 08h+.
// R17 - Read without pointer load starts at the held pointer.
// R18 - Write: first byte loads pointer, later bytes stored then pointer advances.
// R19 - Acknowledge address, word address and every received data byte. The code gives no acknowledge for a data byte while the write FIFO is full.
// R20 - Unmatched address: no acknowledge, line released until next START.
// R21 - Pointer wraps from last location back to zero.
`timescale 1ns/10ps
`default_nettype none
`include "rtcs_defs.vh"

// Small write FIFO, valid/ready on both sides
module rtcs_fifo #(
    parameter WIDTH = 13,
    parameter DEPTH = 4,
    parameter AW = 2
) (
    input wire clk,
    input wire rst_n,
    input wire in_valid,
    output wire in_ready,
    input wire [WIDTH-1:0] in_data,
    output wire out_valid,
    input wire out_ready,
    output wire [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wr_ptr;
    reg [AW-1:0] rd_ptr;
    reg [AW:0] count;
    wire do_wr;
    wire do_rd;

    assign in_ready = (count != DEPTH[AW:0]);
    assign out_valid = (count != {(AW+1){1'b0}});
    assign out_data = mem[rd_ptr];
    assign do_wr = in_valid && in_ready;
    assign do_rd = out_valid && out_ready;

    always @(posedge clk) begin
        if (do_wr) begin
            mem[wr_ptr] <= in_data;
        end
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr <= {AW{1'b0}};
            rd_ptr <= {AW{1'b0}};
            count <= {(AW+1){1'b0}};
        end else begin
            if (do_wr) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (do_rd) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
            if (do_wr && !do_rd) begin
                count <= count + 1'b1;
            end else if (do_rd && !do_wr) begin
                count <= count - 1'b1;
            end
        end
    end
endmodule

// Port proper
module rtcs_port (
    input wire clk,
    input wire rst_n,
    input wire scl,
    input wire sda_in,
    output reg sda_out,
    output reg sda_oe,
    input wire supply_low,
    output reg [4:0] rd_addr,
    input wire [7:0] rd_data,
    output wire wr_valid,
    input wire wr_ready,
    output wire [4:0] wr_addr,
    output wire [7:0] wr_data,
    output reg freeze_update,
    output reg busy
);
    localparam ST_IDLE = 3'h0;
    localparam ST_ADDR = 3'h1;
    localparam ST_WORD = 3'h2;
    localparam ST_DATA = 3'h3;
    localparam ST_SEND = 3'h4;
    localparam ST_RACK = 3'h5;
    localparam ST_IGNORE = 3'h6;

    localparam SYNC_INIT = `RTCS_SYNC_INIT;

    reg scl_d;
    reg sda_d;
    reg [2:0] state;
    reg [3:0] bit_cnt;
    reg [7:0] shift;
    reg [4:0] ptr;
    reg ack_phase;
    reg fifo_in_valid;
    reg [12:0] fifo_in_data;
    wire scl_s;
    wire sda_s;
    wire low_s;
    wire scl_rise;
    wire scl_fall;
    wire start_cond;
    wire stop_cond;
    wire fifo_in_ready;
    wire [12:0] fifo_out_data;
    wire [2:0] pin_raw;
    wire [2:0] pin_sync;
    genvar gi;

    function [4:0] ptr_next;
        input [4:0] p;
        begin
            if (p == `RTCS_LOC_LAST) begin
                ptr_next = `RTCS_PTR_RESET; // R21
            end else begin
                ptr_next = p + 5'h01; // R2
            end
        end
    endfunction

    // Two-flop synchronisers: supply, data, clock
    assign pin_raw = {supply_low, sda_in, scl};
    generate
        for (gi = 0; gi < 3; gi = gi + 1) begin : g_sync
            reg [1:0] ff;
            always @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    ff <= {2{SYNC_INIT[gi]}};
                end else begin
                    ff <= {ff[0], pin_raw[gi]};
                end
            end
            assign pin_sync[gi] = ff[1];
        end
    endgenerate

    assign scl_s = pin_sync[0];
    assign sda_s = pin_sync[1];
    assign low_s = pin_sync[2];
    assign scl_rise = scl_s && !scl_d;
    assign scl_fall = !scl_s && scl_d;
    assign start_cond = scl_s && scl_d && sda_d && !sda_s; // R7 R6
    assign stop_cond = scl_s && scl_d && !sda_d && sda_s; // R8 R6

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end else begin
            scl_d <= scl_s;
            sda_d <= sda_s;
        end
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= ST_IDLE;
            bit_cnt <= 4'h0;
            shift <= 8'h00;
            ptr <= `RTCS_PTR_RESET;
            ack_phase <= 1'b0;
            sda_out <= 1'b0;
            sda_oe <= 1'b0;
            fifo_in_valid <= 1'b0;
            fifo_in_data <= 13'h0000;
            rd_addr <= `RTCS_PTR_RESET;
            busy <= 1'b0;
        end else begin
            if (fifo_in_valid && fifo_in_ready) begin
                fifo_in_valid <= 1'b0;
            end
            rd_addr <= ptr;
            if (low_s) begin
                state <= ST_IDLE; // R3 R4
                ptr <= `RTCS_PTR_RESET; // R3
                sda_oe <= 1'b0;
                ack_phase <= 1'b0;
                busy <= 1'b0;
            end else if (start_cond) begin
                state <= ST_ADDR; // R1 R13
                bit_cnt <= 4'h0;
                ack_phase <= 1'b0;
                sda_oe <= 1'b0;
                busy <= 1'b1;
            end else if (stop_cond) begin
                state <= ST_IDLE; // R8 R10
                sda_oe <= 1'b0;
                ack_phase <= 1'b0;
                busy <= 1'b0;
            end else begin
                case (state)
                    ST_IDLE, ST_IGNORE: begin
                        sda_oe <= 1'b0; // R20 R5
                    end
                    ST_ADDR, ST_WORD, ST_DATA: begin
                        if (!ack_phase) begin
                            if (scl_rise) begin
                                shift <= {shift[6:0], sda_s}; // R9
                                bit_cnt <= bit_cnt + 4'h1;
                            end
                            if (scl_fall && bit_cnt == `RTCS_BITS_PER_BYTE) begin
                                bit_cnt <= 4'h0;
                                if (state == ST_ADDR && shift[`RTCS_ADDR_MSB:1] != `RTCS_DEV_ADDR) begin
                                    state <= ST_IGNORE; // R20
                                end else if (state == ST_DATA && !fifo_in_ready) begin
                                    state <= ST_IGNORE;
                                end else begin
                                    ack_phase <= 1'b1;
                                    sda_out <= 1'b0; // R11 R19
                                    sda_oe <= 1'b1;
                                end
                            end
                        end else if (scl_fall) begin
                            ack_phase <= 1'b0;
                            sda_oe <= 1'b0;
                            if (state == ST_ADDR) begin
                                if (shift[`RTCS_RW_BIT]) begin
                                    state <= ST_SEND; // R17
                                    sda_out <= rd_data[7];
                                    sda_oe <= !rd_data[7];
                                    shift <= {rd_data[6:0], 1'b1};
                                    bit_cnt <= 4'h1;
                                end else begin
                                    state <= ST_WORD;
                                end
                            end else if (state == ST_WORD) begin
                                ptr <= (shift[4:0] > `RTCS_LOC_LAST) ? `RTCS_PTR_RESET : shift[4:0]; // R18 R13
                                state <= ST_DATA;
                            end else begin
                                fifo_in_valid <= 1'b1; // R18
                                fifo_in_data <= {ptr, shift};
                                ptr <= ptr_next(ptr); // R14
                            end
                        end
                    end
                    ST_SEND: begin
                        if (scl_fall) begin
                            if (bit_cnt == `RTCS_BITS_PER_BYTE) begin
                                sda_oe <= 1'b0; // R12
                                state <= ST_RACK;
                            end else begin
                                sda_out <= shift[7];
                                sda_oe <= !shift[7];
                                shift <= {shift[6:0], 1'b1};
                                bit_cnt <= bit_cnt + 4'h1;
                            end
                        end
                    end
                    ST_RACK: begin
                        if (scl_rise) begin
                            ack_phase <= !sda_s;
                            if (!sda_s) begin
                                ptr <= ptr_next(ptr); // R14 R15
                            end
                        end
                        if (scl_fall) begin
                            if (ack_phase) begin
                                state <= ST_SEND; // R15
                                sda_out <= rd_data[7];
                                sda_oe <= !rd_data[7];
                                shift <= {rd_data[6:0], 1'b1};
                                bit_cnt <= 4'h1;
                            end else begin
                                state <= ST_IGNORE; // R12
                            end
                            ack_phase <= 1'b0;
                        end
                    end
                    default: begin
                        state <= ST_IDLE;
                    end
                endcase
            end
        end
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            freeze_update <= 1'b0;
        end else begin
            freeze_update <= busy && !low_s && !stop_cond && (ptr <= `RTCS_CLOCK_LAST); // R16
        end
    end

    rtcs_fifo #(
        .WIDTH(`RTCS_FIFO_WIDTH),
        .DEPTH(`RTCS_FIFO_DEPTH),
        .AW(`RTCS_FIFO_AW)
    ) u_fifo (
        .clk(clk),
        .rst_n(rst_n),
        .in_valid(fifo_in_valid),
        .in_ready(fifo_in_ready),
        .in_data(fifo_in_data),
        .out_valid(wr_valid),
        .out_ready(wr_ready),
        .out_data(fifo_out_data)
    );
    assign wr_addr = fifo_out_data[12:8];
    assign wr_data = fifo_out_data[7:0];
endmodule
`default_nettype wire

// *** verification/rtcs_master.sv ***
// Bus master model: drives the clock line and pulls the data line low.
// Assumes a pull-up on the data wire; paced by the system clock.
`timescale 1ns/10ps
`default_nettype none
module rtcs_master (
    input wire logic clk,
    input wire logic sda,
    output var logic scl,
    output var logic sda_low
);
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    task automatic w(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic send_bit(input logic v, output logic r);
        sda_low = ~v;
        w(2);
        scl = 1'b1;
        w(2);
        r = sda;
        w(2);
        scl = 1'b0;
        w(2);
    endtask
    task automatic start();
        sda_low = 1'b0;
        w(6);
        scl = 1'b1;
        w(8);
        sda_low = 1'b1;
        w(8);
        scl = 1'b0;
        w(2);
    endtask
    task automatic stop();
        sda_low = 1'b1;
        w(6);
        scl = 1'b1;
        w(8);
        sda_low = 1'b0;
        w(16);
    endtask
    task automatic wbyte(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) send_bit(b[i], r);
        send_bit(1'b1, r);
        ack = ~r;
    endtask
    task automatic rbyte(input logic ack, output logic [7:0] b);
        logic r;
        for (int i = 7; i >= 0; i--) send_bit(1'b1, b[i]);
        send_bit(~ack, r);
    endtask
endmodule
`default_nettype wire

// *** verification/rtcs_port_asserts.sv ***
// Pin-level assertions for the two-wire slave port.
// Assumes a bind onto rtcs_port and a master keeping legal bus timing.
`timescale 1ns/10ps
`default_nettype none
module rtcs_port_asserts (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic scl,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire logic supply_low,
    input wire logic [4:0] rd_addr,
    input wire logic wr_valid,
    input wire logic wr_ready,
    input wire logic [4:0] wr_addr,
    input wire logic [7:0] wr_data,
    input wire logic freeze_update,
    input wire logic busy
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_start_busy: assert property ($fell(sda_in) && scl && $past(scl) && !supply_low |-> ##[2:5] busy)
        else $error("start not followed by busy");
    a_stop_idle: assert property ($rose(sda_in) && scl && $past(scl) |-> ##[2:5] !busy)
        else $error("stop not followed by idle");
    a_supply_abort: assert property ($rose(supply_low) |-> ##4 (!busy && !sda_oe))
        else $error("low supply did not abort");
    a_supply_ignore: assert property (supply_low && $past(supply_low, 4) |-> !busy && !sda_oe && !freeze_update)
        else $error("activity while supply low");
    a_drive_low: assert property (sda_oe |-> !sda_out)
        else $error("data driven high");
    a_ack_steady: assert property (sda_oe && $rose(scl) |-> sda_oe [*6])
        else $error("data drive changed while clock high");
    a_oe_in_frame: assert property (sda_oe |-> busy || $past(busy))
        else $error("data driven outside a transfer");
    a_freeze_frame: assert property (freeze_update |-> busy || $past(busy))
        else $error("freeze held after transfer");
    a_ptr_range: assert property (rd_addr <= 5'h13)
        else $error("pointer beyond last location");
    a_wr_hold: assert property (wr_valid && !wr_ready |=> wr_valid && $stable(wr_addr) && $stable(wr_data))
        else $error("write request dropped or changed");
    cover property (wr_valid && wr_ready);
    cover property ($fell(busy));
    cover property (freeze_update && busy);
endmodule
bind rtcs_port rtcs_port_asserts chk (.clk, .rst_n, .scl, .sda_in, .sda_out, .sda_oe, .supply_low,
    .rd_addr, .wr_valid, .wr_ready, .wr_addr, .wr_data, .freeze_update, .busy);
`default_nettype wire

// *** verification/rtcs_port_test.sv ***
// Self-checking bench for the two-wire slave port.
// Assumes rtcs_master on the bus and a byte array standing in for storage.
`timescale 1ns/10ps
`default_nettype none
module rtcs_port_test;
    logic clk;
    logic rst_n;
    logic supply_low;
    logic wr_ready;
    logic scl, sda_low, sda_out, sda_oe, wr_valid, freeze_update, busy;
    logic [4:0] rd_addr, wr_addr;
    logic [7:0] wr_data, rd_data;
    logic [7:0] mem [0:19];
    wire logic sda_in = ~(sda_low | sda_oe);
    int err_count = 0;
    int compares = 0;
    always #50 clk = ~clk;
    assign rd_data = mem[rd_addr];
    always @(posedge clk) if (wr_valid && wr_ready) mem[wr_addr] <= wr_data;
    rtcs_port dut (.clk, .rst_n, .scl, .sda_in, .sda_out, .sda_oe, .supply_low, .rd_addr,
        .rd_data, .wr_valid, .wr_ready, .wr_addr, .wr_data, .freeze_update, .busy);
    rtcs_master m (.clk, .sda(sda_in), .scl, .sda_low);
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic test_done();
        if (err_count == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic t_write();
        logic a;
        wr_ready = 1'b0;
        m.start();
        m.wbyte(8'hD0, a);
        check(8'(a), 8'h01);
        m.wbyte(8'h06, a);
        check(8'(a), 8'h01);
        for (logic [7:0] i = 0; i < 5; i++) begin
            m.wbyte(8'hA0 + i, a);
            m.w(8);
            check(8'(a), 8'(i < 4));
            if (i < 2) check(8'(freeze_update), 8'(i == 0));
        end
        m.stop();
        check(8'(busy), 8'h00);
        wr_ready = 1'b1;
        for (int k = 0; k < 50 && wr_valid !== 1'b0; k++)
            m.w(1);
        if (wr_valid !== 1'b0) begin
            err_count++;
            test_done();
        end
        for (logic [7:0] k = 0; k < 5; k++) check(mem[6 + k], k < 4 ? 8'hA0 + k : 8'h3A);
    endtask
    task automatic t_cur_read(input logic [7:0] exp);
        logic a;
        logic [7:0] d;
        m.start();
        m.wbyte(8'hD1, a);
        m.rbyte(1'b0, d);
        m.stop();
        check(d, exp);
    endtask
    task automatic t_seq_read();
        logic a;
        logic [7:0] d;
        m.start();
        m.wbyte(8'hD0, a);
        m.wbyte(8'h12, a);
        m.start();
        m.wbyte(8'hD1, a);
        check(8'(a), 8'h01);
        m.rbyte(1'b1, d);
        check(d, 8'h42);
        m.rbyte(1'b1, d);
        check(d, 8'h43);
        m.rbyte(1'b0, d);
        check(d, 8'h30);
        m.w(8);
        check(8'(sda_oe), 8'h00);
        m.stop();
    endtask
    task automatic t_nomatch();
        logic a;
        m.start();
        m.wbyte(8'hA0, a);
        check(8'(a), 8'h00);
        m.wbyte(8'hD0, a);
        check(8'(a), 8'h00);
        m.stop();
    endtask
    task automatic t_supply();
        logic a;
        m.start();
        m.wbyte(8'hD0, a);
        m.wbyte(8'h11, a);
        supply_low = 1'b1;
        m.w(8);
        check(8'(busy), 8'h00);
        m.wbyte(8'h55, a);
        check(8'(a), 8'h00);
        m.stop();
        m.start();
        m.wbyte(8'hD0, a);
        check(8'(a), 8'h00);
        m.stop();
        supply_low = 1'b0;
        m.w(8);
        check(mem[17], 8'h41);
    endtask
    initial begin
        clk = 1'b0;
        rst_n = 1'b0;
        supply_low = 1'b0;
        wr_ready = 1'b1;
        for (int i = 0; i < 20; i++) mem[i] = 8'h30 + 8'(i);
        repeat (6) @(posedge clk);
        #1;
        rst_n = 1'b1;
        m.w(4);
        t_write();
        t_cur_read(8'h3A);
        t_seq_read();
        t_nomatch();
        t_supply();
        t_cur_read(8'h30);
        test_done();
    end
    initial begin
        repeat (40000) @(posedge clk);
        err_count++;
        test_done();
    end
endmodule
`default_nettype wire
